//--- srcs_pkg.sv
// srcs_pkg: register indices, field positions, reset values, state codes and timing
// constants for the reference capture and sync block.
// assumes: byte address of a register is four times its index.
`default_nettype none
package srcs_pkg;
  localparam int          CLK_PERIOD_PS   = 25000;
  localparam int          ADDR_W          = 16;
  localparam int          IDX_W           = 12;
  localparam int          SMP_W           = 14;
  localparam int          DLY_W           = 4;
  localparam int          CNT_W           = 4;
  localparam int          IGN_W           = 5;
  localparam int          NCB             = 3;
  // register indices
  localparam logic [11:0] IDX_CTRL        = 12'h120;
  localparam logic [11:0] IDX_IGNORE      = 12'h121;
  localparam logic [11:0] IDX_TSDLY       = 12'h123;
  localparam logic [11:0] IDX_MONITOR     = 12'h128;
  localparam logic [11:0] IDX_MONFLAG     = 12'h129;
  localparam logic [11:0] IDX_SYNCMODE    = 12'h1ff;
  localparam logic [11:0] IDX_APPMODE     = 12'h200;
  localparam logic [11:0] IDX_CBFUNC01    = 12'h559;
  localparam logic [11:0] IDX_CBFUNC2     = 12'h55a;
  localparam logic [11:0] IDX_CBCOUNT     = 12'h58f;
  // field positions
  localparam int          CTRL_MODE_LO    = 1;
  localparam int          CTRL_EDGE_BIT   = 3;
  localparam int          CTRL_POL_BIT    = 4;
  localparam int          CBF0_LO         = 0;
  localparam int          CBF1_LO         = 4;
  localparam int          CBCOUNT_LO      = 6;
  localparam int          MON_HOLD_LO     = 4;
  // field values
  localparam logic [1:0]  MODE_OFF        = 2'h0;
  localparam logic [1:0]  MODE_CONT       = 2'h1;
  localparam logic [1:0]  MODE_NSHOT      = 2'h2;
  localparam logic [2:0]  CBF_SYSREF      = 3'h5;
  localparam logic [4:0]  IGNORE_MAX      = 5'h10;
  localparam logic [3:0]  CNT_SAT         = 4'hf;
  localparam logic [3:0]  MON_GOOD        = 4'h8;
  localparam logic [3:0]  MON_ZERO        = 4'h0;
  localparam logic [3:0]  ALIGN_ALL       = 4'hf;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  // state codes, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_FIRE = 3'b100
  } srcs_state_t;
endpackage
`default_nettype wire

//--- srcs_delay_mem.sv
// srcs_delay_mem: small ring memory that delays tagged sample words by a programmable count.
// assumes: one word written every clock; read data registered, so total delay is dly + 1.
`default_nettype none
module srcs_delay_mem #(
  parameter int WIDTH = 29
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [srcs_pkg::DLY_W-1:0]  dly,
  input  wire logic [WIDTH-1:0]            wdata,
  output logic      [WIDTH-1:0]            rdata
);
  localparam int DEPTH = 1 << srcs_pkg::DLY_W;
  logic [WIDTH-1:0]            mem [DEPTH];
  logic [srcs_pkg::DLY_W-1:0]  wptr_reg;
  logic [srcs_pkg::DLY_W-1:0]  wptr_next;
  logic [srcs_pkg::DLY_W-1:0]  rptr;

  always_comb begin
    wptr_next = wptr_reg + 1'b1;
    rptr      = wptr_reg - dly;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rdata    <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rdata    <= (dly == '0) ? wdata : mem[rptr];
    end
  end

  // storage has no reset: for the first dly clocks after reset the read side returns unwritten entries
  always_ff @(posedge pclk) begin
    mem[wptr_reg] <= wdata;
  end
endmodule // srcs_delay_mem
`default_nettype wire

//--- srcs_top.sv
// srcs_top: reference pulse capture, multichip sync and sample timestamping, APB slave.
// assumes: sysref_in and sample inputs synchronous to pclk; one sample per channel per clock.
// Functional notes
// - one bit picks sample or timestamp sync
// - sample sync: event realigns divider, downconverters, monitor, link
// - timestamp sync: clocks untouched, coincident sample tagged
// - no timestamp while decimation is selected
// - three-bit function per control bit, 5 is timestamp
// - tag only the sample at the reference edge
// - both channels share one pipeline latency
// - delay setting shifts which sample gets tagged; here it delays tag and both samples together, so only the latency moves
// - mode field: 1 continuous, 2 N-shot, nonzero arms
// - N-shot mode field clears itself after event
// - multiframe rate is clock over S times K
// - event is rising or falling transition, selectable
// - reference sampled on rising or falling clock edge
// - N-shot ignores programmable count up to 16 events
// - monitor reads hold high nibble, setup low nibble
// - monitor codes decode to setup, hold, both, or no error
// - polarity choice is control bit 4
// - clock edge choice is control bit 3
`default_nettype none
module srcs_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [srcs_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          sysref_in,
  input  wire logic [srcs_pkg::SMP_W-1:0]    sample_a,
  input  wire logic [srcs_pkg::SMP_W-1:0]    sample_b,
  output logic      [srcs_pkg::SMP_W-1:0]    dout_a,
  output logic      [srcs_pkg::SMP_W-1:0]    dout_b,
  output logic      [srcs_pkg::NCB-1:0]      ctrl_bits,
  output logic      [3:0]                    realign
);
  localparam int MW = 2 * srcs_pkg::SMP_W + 1;

  function automatic logic [srcs_pkg::IDX_W-1:0] reg_index(input logic [srcs_pkg::ADDR_W-1:0] a);
    reg_index = a[srcs_pkg::IDX_W+1:2];
  endfunction

  function automatic logic is_mapped(input logic [srcs_pkg::ADDR_W-1:0] a);
    logic [srcs_pkg::IDX_W-1:0] i;
    i = reg_index(a);
    is_mapped = (a[1:0] == 2'h0) && (a[srcs_pkg::ADDR_W-1:srcs_pkg::IDX_W+2] == '0) &&
                (i == srcs_pkg::IDX_CTRL || i == srcs_pkg::IDX_IGNORE || i == srcs_pkg::IDX_TSDLY ||
                 i == srcs_pkg::IDX_MONITOR || i == srcs_pkg::IDX_MONFLAG || i == srcs_pkg::IDX_SYNCMODE ||
                 i == srcs_pkg::IDX_APPMODE || i == srcs_pkg::IDX_CBFUNC01 || i == srcs_pkg::IDX_CBFUNC2 ||
                 i == srcs_pkg::IDX_CBCOUNT);
  endfunction

  // registers
  logic [7:0] ctrl_reg,  ctrl_next;
  logic [4:0] ign_reg,   ign_next;
  logic [3:0] tsdly_reg, tsdly_next;
  logic       sync_reg,  sync_next;
  logic       decim_reg, decim_next;
  logic [7:0] cbf01_reg, cbf01_next;
  logic [2:0] cbf2_reg,  cbf2_next;
  logic [1:0] cbcnt_reg, cbcnt_next;
  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;

  // capture path
  logic                       ref_neg_reg;
  logic                       ref_cur_reg, ref_prev_reg;
  logic                       event_w;
  srcs_pkg::srcs_state_t      st_reg, st_next;
  logic [4:0]                 ignc_reg, ignc_next;
  logic                       fire_w;
  logic [3:0]                 realign_next;
  logic                       ts_tag_w;
  logic [3:0]                 setup_cnt_reg, setup_cnt_next;
  logic [3:0]                 hold_cnt_reg,  hold_cnt_next;
  logic                       hold_run_reg,  hold_run_next;
  logic [7:0]                 mon_reg, mon_next;
  logic [1:0]                 monflag_w;
  logic [MW-1:0]              mem_rdata;
  logic [srcs_pkg::NCB-1:0]   cb_sel;
  logic [srcs_pkg::NCB-1:0]   ctrl_bits_next;

  wire logic [1:0] mode_w  = ctrl_reg[srcs_pkg::CTRL_MODE_LO +: 2];
  wire logic       wr_w    = psel && penable && pready && pwrite && !pslverr;
  wire logic [srcs_pkg::IDX_W-1:0] widx = reg_index(paddr);

  // decodes the margin monitor into setup error (bit 0) and hold error (bit 1)
  function automatic logic [1:0] mon_decode(input logic [7:0] m);
    logic [3:0] h;
    logic [3:0] s;
    h = m[7:4];
    s = m[3:0];
    mon_decode = 2'b00;
    if (h == srcs_pkg::MON_ZERO && s == srcs_pkg::MON_ZERO) mon_decode = 2'b11;
    else if (s == srcs_pkg::MON_GOOD) mon_decode = 2'b00;
    else if (h == srcs_pkg::MON_ZERO && s < srcs_pkg::MON_GOOD) mon_decode = 2'b01;
    else if (h > srcs_pkg::MON_GOOD && s == srcs_pkg::MON_ZERO) mon_decode = 2'b10;
  endfunction

  // APB: setup cycle decodes and prepares the answer; access cycle completes with one wait-free edge
  always_comb begin
    pready_next  = psel && !penable;
    pslverr_next = psel && !penable && !is_mapped(paddr);
    prdata_next  = '0;
    if (psel && !penable && !pwrite && is_mapped(paddr)) begin
      unique case (widx)
        srcs_pkg::IDX_CTRL:     prdata_next[7:0] = ctrl_reg;
        srcs_pkg::IDX_IGNORE:   prdata_next[4:0] = ign_reg;
        srcs_pkg::IDX_TSDLY:    prdata_next[3:0] = tsdly_reg;
        srcs_pkg::IDX_MONITOR:  prdata_next[7:0] = mon_reg;
        srcs_pkg::IDX_MONFLAG:  prdata_next[1:0] = monflag_w;
        srcs_pkg::IDX_SYNCMODE: prdata_next[0]   = sync_reg;
        srcs_pkg::IDX_APPMODE:  prdata_next[0]   = decim_reg;
        srcs_pkg::IDX_CBFUNC01: prdata_next[7:0] = cbf01_reg;
        srcs_pkg::IDX_CBFUNC2:  prdata_next[2:0] = cbf2_reg;
        default:                prdata_next[7:6] = cbcnt_reg;
      endcase
    end
  end

  always_comb begin
    ctrl_next  = ctrl_reg;
    ign_next   = ign_reg;
    tsdly_next = tsdly_reg;
    sync_next  = sync_reg;
    decim_next = decim_reg;
    cbf01_next = cbf01_reg;
    cbf2_next  = cbf2_reg;
    cbcnt_next = cbcnt_reg;
    // hardware self-clear of the N-shot field; a control register write in the same cycle overrides it
    if (fire_w && mode_w == srcs_pkg::MODE_NSHOT) ctrl_next[srcs_pkg::CTRL_MODE_LO +: 2] = srcs_pkg::MODE_OFF;
    if (wr_w) begin
      unique case (widx)
        srcs_pkg::IDX_CTRL:     ctrl_next  = pwdata[7:0];
        srcs_pkg::IDX_IGNORE:   ign_next   = (pwdata[4:0] > srcs_pkg::IGNORE_MAX) ? srcs_pkg::IGNORE_MAX
                                                                                  : pwdata[4:0];
        srcs_pkg::IDX_TSDLY:    tsdly_next = pwdata[3:0];
        srcs_pkg::IDX_SYNCMODE: sync_next  = pwdata[0];
        srcs_pkg::IDX_APPMODE:  decim_next = pwdata[0];
        srcs_pkg::IDX_CBFUNC01: cbf01_next = pwdata[7:0];
        srcs_pkg::IDX_CBFUNC2:  cbf2_next  = pwdata[2:0];
        srcs_pkg::IDX_CBCOUNT:  cbcnt_next = pwdata[7:6];
        default:                ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= srcs_pkg::RST_BYTE;
      ign_reg   <= '0;
      tsdly_reg <= '0;
      sync_reg  <= 1'b0;
      decim_reg <= 1'b0;
      cbf01_reg <= srcs_pkg::RST_BYTE;
      cbf2_reg  <= '0;
      cbcnt_reg <= '0;
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      ign_reg   <= ign_next;
      tsdly_reg <= tsdly_next;
      sync_reg  <= sync_next;
      decim_reg <= decim_next;
      cbf01_reg <= cbf01_next;
      cbf2_reg  <= cbf2_next;
      cbcnt_reg <= cbcnt_next;
      prdata    <= prdata_next;
      pready    <= pready_next;
      pslverr   <= pslverr_next;
    end
  end

  // falling-edge sample; it is then retimed to the rising edge like the rising-edge sample
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) ref_neg_reg <= 1'b0;
    else          ref_neg_reg <= sysref_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cur_reg  <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      ref_cur_reg  <= ctrl_reg[srcs_pkg::CTRL_EDGE_BIT] ? ref_neg_reg : sysref_in;
      ref_prev_reg <= ref_cur_reg;
    end
  end

  // a pulse narrower than one clock may be missed, which is why the source must widen it
  assign event_w = ctrl_reg[srcs_pkg::CTRL_POL_BIT] ? (ref_prev_reg && !ref_cur_reg)
                                                    : (!ref_prev_reg && ref_cur_reg);

  always_comb begin
    st_next   = st_reg;
    ignc_next = ignc_reg;
    fire_w    = 1'b0;
    unique case (st_reg)
      srcs_pkg::ST_IDLE: begin
        ignc_next = '0;
        if (mode_w != srcs_pkg::MODE_OFF) st_next = srcs_pkg::ST_ARM;
      end
      srcs_pkg::ST_ARM: begin
        if (mode_w == srcs_pkg::MODE_OFF) begin
          st_next = srcs_pkg::ST_IDLE;
        end else if (event_w) begin
          if (mode_w == srcs_pkg::MODE_NSHOT && ignc_reg < ign_reg) begin
            ignc_next = ignc_reg + 1'b1;
          end else begin
            fire_w  = 1'b1;
            st_next = srcs_pkg::ST_FIRE;
          end
        end
      end
      srcs_pkg::ST_FIRE: begin
        // continuous mode re-arms at once; N-shot has just cleared its field and drops to idle
        st_next = (mode_w == srcs_pkg::MODE_CONT) ? srcs_pkg::ST_ARM : srcs_pkg::ST_IDLE;
      end
      default: st_next = srcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= srcs_pkg::ST_IDLE;
      ignc_reg <= '0;
    end else begin
      st_reg   <= st_next;
      ignc_reg <= ignc_next;
    end
  end

  // sample sync realigns all four targets; timestamp sync leaves them and tags the sample instead unless decimation is selected
  assign realign_next = (fire_w && !sync_reg) ? srcs_pkg::ALIGN_ALL : '0;
  assign ts_tag_w     = fire_w && sync_reg && !decim_reg;

  // margin monitor: setup = clocks of stable level before the event, hold = clocks it stays after
  always_comb begin
    setup_cnt_next = (ref_cur_reg != ref_prev_reg) ? '0 :
                     (setup_cnt_reg == srcs_pkg::CNT_SAT) ? setup_cnt_reg : setup_cnt_reg + 1'b1;
    hold_run_next  = hold_run_reg;
    hold_cnt_next  = hold_cnt_reg;
    mon_next       = mon_reg;
    if (event_w) begin
      hold_run_next = 1'b1;
      hold_cnt_next = '0;
      mon_next[3:0] = setup_cnt_reg;
    end else if (hold_run_reg) begin
      if (ref_cur_reg != ref_prev_reg) begin
        hold_run_next = 1'b0;
        mon_next[7:srcs_pkg::MON_HOLD_LO] = hold_cnt_reg;
      end else if (hold_cnt_reg != srcs_pkg::CNT_SAT) begin
        hold_cnt_next = hold_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_cnt_reg <= '0;
      hold_cnt_reg  <= '0;
      hold_run_reg  <= 1'b0;
      mon_reg       <= srcs_pkg::RST_BYTE;
    end else begin
      setup_cnt_reg <= setup_cnt_next;
      hold_cnt_reg  <= hold_cnt_next;
      hold_run_reg  <= hold_run_next;
      mon_reg       <= mon_next;
    end
  end

  assign monflag_w = mon_decode(mon_reg);

  // one shared delay line keeps both channels and the tag on the same latency
  srcs_delay_mem #(.WIDTH(MW)) u_dly (
    .pclk    (pclk),
    .presetn (presetn),
    .dly     (tsdly_reg),
    .wdata   ({ts_tag_w, sample_a, sample_b}),
    .rdata   (mem_rdata)
  );

  wire logic [2:0] cbf_w [srcs_pkg::NCB];
  assign cbf_w[0] = cbf01_reg[srcs_pkg::CBF0_LO +: 3];
  assign cbf_w[1] = cbf01_reg[srcs_pkg::CBF1_LO +: 3];
  assign cbf_w[2] = cbf2_reg;

  genvar gi;
  generate
    for (gi = 0; gi < srcs_pkg::NCB; gi++) begin : g_cb
      // a bit carries the tag only if enabled by the count field and set to the timestamp function
      assign cb_sel[gi] = (cbcnt_reg > gi) && (cbf_w[gi] == srcs_pkg::CBF_SYSREF);
      assign ctrl_bits_next[gi] = cb_sel[gi] && mem_rdata[MW-1];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_a    <= '0;
      dout_b    <= '0;
      ctrl_bits <= '0;
      realign   <= '0;
    end else begin
      dout_a    <= mem_rdata[MW-2 -: srcs_pkg::SMP_W];
      dout_b    <= mem_rdata[srcs_pkg::SMP_W-1:0];
      ctrl_bits <= ctrl_bits_next;
      realign   <= realign_next;
    end
  end

  default clocking cb_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  realign_on_fire_a: assert property (fire_w && !sync_reg |=> realign == srcs_pkg::ALIGN_ALL)
    else $error("realign missing after event in sample sync");
  no_realign_ts_a: assert property (sync_reg && $past(sync_reg) |-> realign == '0)
    else $error("realign pulsed in timestamp sync");
  idle_when_off_a: assert property (mode_w == srcs_pkg::MODE_OFF |=> !fire_w)
    else $error("event acted on with mode off");
  nshot_clears_a: assert property (fire_w && mode_w == srcs_pkg::MODE_NSHOT && !wr_w
                                   |=> mode_w == srcs_pkg::MODE_OFF)
    else $error("n-shot mode not self-cleared");
  ignore_count_a: assert property (fire_w && mode_w == srcs_pkg::MODE_NSHOT |-> ignc_reg == ign_reg)
    else $error("n-shot fired before ignore count");
  no_tag_decim_a: assert property (decim_reg && $past(decim_reg, 2) |-> !ts_tag_w || !$past(ts_tag_w))
    else $error("timestamp tagged while decimating");
  tag_latency_a: assert property (ts_tag_w && tsdly_reg == '0 && cb_sel[0] && $stable(tsdly_reg)
                                  ##1 cb_sel[0] |=> ctrl_bits[0])
    else $error("timestamp bit not at tagged sample");
  edge_rise_a: assert property (!ctrl_reg[srcs_pkg::CTRL_POL_BIT] && event_w |-> ref_cur_reg && !ref_prev_reg)
    else $error("rising event without rising transition");
  monitor_setup_a: assert property (event_w |=> mon_reg[3:0] == $past(setup_cnt_reg))
    else $error("setup status not latched at event");

  fire_cont_c:  cover property (fire_w && mode_w == srcs_pkg::MODE_CONT);
  fire_nshot_c: cover property (fire_w && mode_w == srcs_pkg::MODE_NSHOT && ign_reg != '0);
  tag_out_c:    cover property (ctrl_bits != '0);
  realign_c:    cover property (realign != '0);
endmodule // srcs_top
`default_nettype wire

//--- srcs_refgen.sv
// srcs_refgen: clock generator model that drives single reference pulses on request.
// assumes: trig is a one-cycle request launched after a rising edge of pclk.
`default_nettype none
module srcs_refgen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       trig,
  input  wire logic [3:0] width,
  output logic            sysref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] left_reg;
  // single pulses only: a periodic train could couple into the sampling path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg   <= 5'h00;
      sysref_out <= 1'b0;
    end else if (trig) begin
      // never narrower than two clocks, the divider is not modelled
      left_reg   <= (width < 4'h2) ? 5'h01 : {1'b0, width} - 5'h01;
      sysref_out <= 1'b1;
    end else if (left_reg != 5'h00) begin
      left_reg   <= left_reg - 5'h01;
    end else begin
      sysref_out <= 1'b0;
    end
  end
endmodule // srcs_refgen
`default_nettype wire

//--- test_sysref_capture_sync_timestamp.sv
// test_sysref_capture_sync_timestamp: APB-driven checks of capture, sync and timestamp tagging.
// assumes: srcs_pkg compiled first; srcs_refgen stands in for the reference source.
`default_nettype none
module test_sysref_capture_sync_timestamp;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        pclk = 1'b0;
  logic                        presetn = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [srcs_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0]                 pwdata = '0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        sysref_in;
  logic                        trig = 1'b0;
  logic [srcs_pkg::SMP_W-1:0]  smp = '0;
  logic [srcs_pkg::SMP_W-1:0]  sample_a = '0;
  logic [srcs_pkg::SMP_W-1:0]  sample_b = '0;
  logic [srcs_pkg::SMP_W-1:0]  dout_a;
  logic [srcs_pkg::SMP_W-1:0]  dout_b;
  logic [srcs_pkg::NCB-1:0]    ctrl_bits;
  logic [3:0]                  realign;
  logic [31:0]                 rd;
  logic                        err;
  logic [3:0]                  rl;
  logic [2:0]                  cb;
  logic [srcs_pkg::SMP_W-1:0]  da;
  logic [srcs_pkg::SMP_W-1:0]  db;
  int                          failures = 0;
  int                          samples_checked = 0;
  int                          lat;
  int                          lat2;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    smp      <= smp + 14'h0001;
    sample_a <= smp;
    sample_b <= ~smp;
  end
  srcs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysref_in(sysref_in), .sample_a(sample_a), .sample_b(sample_b), .dout_a(dout_a),
    .dout_b(dout_b), .ctrl_bits(ctrl_bits), .realign(realign));
  srcs_refgen partner (.pclk(pclk), .presetn(presetn), .trig(trig), .width(4'h4), .sysref_out(sysref_in));
  task automatic end_sim();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  // read data and error taken only at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        failures++;
        end_sim();
      end
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge pclk);
  endtask
  // one pulse; cycles until realign or a control bit shows, -1 if none within 40
  task automatic fire(output int l);
    int n;
    l = -1;
    trig <= 1'b1;
    @(posedge pclk);
    trig <= 1'b0;
    for (n = 1; n <= 40 && l < 0; n++) begin
      @(negedge pclk);
      if (realign !== 4'h0 || ctrl_bits !== 3'h0) begin
        l  = n;
        rl = realign;
        cb = ctrl_bits;
        da = dout_a;
        db = dout_b;
      end
    end
    repeat (30) @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, srcs_pkg::IDX_SYNCMODE, 32'h0); chk(rd, 32'h0);
    apb(1'b0, srcs_pkg::IDX_CTRL, 32'h0); chk(rd, 32'h0);
    apb(1'b0, srcs_pkg::IDX_MONITOR, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 12'h300, 32'h0); chk({err, rd[30:0]}, 32'h80000000);
    fire(lat); chk(lat, -1);
    $display("test reset and idle done");
    apb(1'b1, srcs_pkg::IDX_CTRL, 32'h02);
    fire(lat); chk({rl, 1'b0, cb}, 8'hf0);
    apb(1'b1, srcs_pkg::IDX_CTRL, 32'h12);
    fire(lat2); chk(lat2 - lat, 4);
    apb(1'b1, srcs_pkg::IDX_CTRL, 32'h0a);
    fire(lat2); chk(rl, 4'hf);
    $display("test sample sync done");
    apb(1'b1, srcs_pkg::IDX_IGNORE, 32'h2);
    apb(1'b1, srcs_pkg::IDX_CTRL, 32'h04);
    fire(lat); chk(lat, -1);
    fire(lat); chk(lat, -1);
    fire(lat); chk(rl, 4'hf);
    apb(1'b0, srcs_pkg::IDX_CTRL, 32'h0); chk(rd[2:1], 2'h0);
    fire(lat); chk(lat, -1);
    $display("test n-shot done");
    apb(1'b1, srcs_pkg::IDX_SYNCMODE, 32'h1);
    apb(1'b1, srcs_pkg::IDX_CBCOUNT, 32'h40);
    apb(1'b1, srcs_pkg::IDX_CBFUNC01, 32'h05);
    apb(1'b1, srcs_pkg::IDX_CTRL, 32'h02);
    fire(lat); chk({rl, 1'b0, cb}, 8'h01);
    chk(db ^ da, 14'h3fff);
    apb(1'b1, srcs_pkg::IDX_TSDLY, 32'h3);
    fire(lat2); chk(lat2 - lat, 3);
    apb(1'b1, srcs_pkg::IDX_APPMODE, 32'h1);
    fire(lat); chk(lat, -1);
    apb(1'b1, srcs_pkg::IDX_APPMODE, 32'h0);
    apb(1'b1, srcs_pkg::IDX_CBCOUNT, 32'h0);
    fire(lat); chk(lat, -1);
    apb(1'b1, srcs_pkg::IDX_CBCOUNT, 32'hc0);
    apb(1'b1, srcs_pkg::IDX_CBFUNC01, 32'h50);
    fire(lat); chk(cb, 3'b010);
    apb(1'b1, srcs_pkg::IDX_CBFUNC01, 32'h00);
    apb(1'b1, srcs_pkg::IDX_CBFUNC2, 32'h05);
    fire(lat); chk(cb, 3'b100);
    $display("test timestamp done");
    end_sim();
  end
endmodule // test_sysref_capture_sync_timestamp
`default_nettype wire
